// *** lcd_port_pkg.sv ***
`default_nettype none
package lcd_port_pkg;

  localparam int unsigned WIDE_W   = 8;
  localparam int unsigned NARROW_W = 4;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_W    = 16;

  // printed offsets are not word aligned: kept as indices, byte address = 4 * index
  localparam logic [IDX_W-1:0] WIDE_DATA_IDX   = 16'hFFDC;
  localparam logic [IDX_W-1:0] NARROW_DATA_IDX = 16'hFFDD;
  localparam logic [IDX_W-1:0] WIDE_DIR_IDX    = 16'hFFEC;
  localparam logic [IDX_W-1:0] NARROW_DIR_IDX  = 16'hFFED;

  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = IDX_LSB + IDX_W - 1;

  localparam logic [REG_W-1:0] WIDE_DATA_RST   = 8'h00;
  localparam logic [REG_W-1:0] WIDE_DIR_RST    = 8'h00;
  localparam logic [REG_W-1:0] NARROW_DATA_RST = 8'hF0;
  localparam logic [REG_W-1:0] NARROW_DIR_RST  = 8'hF0;
  localparam logic [REG_W-1:0] DIR_READ_VALUE  = 8'hFF;
  localparam logic [REG_W-NARROW_W-1:0] NARROW_UPPER_ONES = 4'hF;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic       HRESP_OKAY        = 1'h0;

  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } power_mode_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_DATA
  } bus_phase_t;

endpackage
`default_nettype wire

// *** lcd_pin_mode_decode.sv ***
`default_nettype none
module lcd_pin_mode_decode #(
  parameter bit HOLD_IN_SUBSLEEP = 1'b1
) (
  input  wire lcd_port_pkg::power_mode_t power_mode_i,
  output logic                           float_o,
  output logic                           hold_o
);
  import lcd_port_pkg::*;

  always_comb begin
    float_o = 1'b0;
    hold_o  = 1'b0;
    unique case (power_mode_i)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        hold_o = 1'b0;
      end
      MODE_SLEEP, MODE_WATCH: begin
        hold_o = 1'b1;
      end
      MODE_SUBSLEEP: begin
        hold_o = HOLD_IN_SUBSLEEP;
      end
      MODE_STANDBY: begin
        float_o = 1'b1;
      end
      default: begin
        float_o = 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** lcd_port_slice.sv ***
`default_nettype none
module lcd_port_slice #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             arst_n_i,
  input  wire logic             wr_data_i,
  input  wire logic             wr_dir_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic             float_i,
  input  wire logic             hold_i,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_o
);

  typedef struct packed {
    logic [WIDTH-1:0] data;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
  } slice_state_t;

  slice_state_t state_reg;
  slice_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_data_i) begin
      state_next.data = wdata_i;
    end
    if (wr_dir_i) begin
      state_next.dir = wdata_i;
    end
    // float wins over hold so standby never leaves a stale driver on
    if (float_i) begin
      state_next.pin_oe = '0;
    end else if (!hold_i) begin
      state_next.pin_out = state_reg.data;
      state_next.pin_oe  = state_reg.dir;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      assign rd_data_o[b] = state_reg.dir[b] ? state_reg.data[b] : pin_i[b];
    end
  endgenerate

  assign pin_o    = state_reg.pin_out;
  assign pin_oe_o = state_reg.pin_oe;

endmodule
`default_nettype wire

// *** lcd_internal_io_ports.sv ***
// What this block does
// - wide port gives eight bidirectional pins toward the LCD controller.
// - narrow port gives four bidirectional pins toward the LCD controller.
// - wide data register latches eight output bits, clears to zero on reset.
// - wide direction one: data read returns the latched value.
// - wide direction zero: data read returns the pin level.
// - wide direction one drives the pin, zero leaves it input.
// - wide direction register is write only and reads all ones.
// - wide direction register resets to zero, all pins input.
// - wide pins float in reset/standby, hold in sleep/subsleep/watch, work otherwise.
// - narrow data uses bits 3..0, upper bits read one, resets F0.
// - narrow direction one: data read returns the latched value.
// - narrow direction zero: data read returns the pin level.
// - narrow direction bits 3..0 select output on one, input on zero.
// - narrow direction register is write only and reads all ones.
// - narrow direction register resets to F0, pins input.
// - narrow pins float in reset/standby, hold in sleeps/watch, work otherwise.
`default_nettype none
module lcd_internal_io_ports (
  input  wire logic                                  mclk_i,
  input  wire logic                                  arst_n_i,
  input  wire logic                                  hsel_i,
  input  wire logic [31:0]                           haddr_i,
  input  wire logic [1:0]                            htrans_i,
  input  wire logic                                  hwrite_i,
  input  wire logic [2:0]                            hsize_i,
  input  wire logic                                  hready_i,
  input  wire logic [31:0]                           hwdata_i,
  output logic      [31:0]                           hrdata_o,
  output logic                                      hreadyout_o,
  output logic                                      hresp_o,
  input  wire lcd_port_pkg::power_mode_t             power_mode_i,
  input  wire logic [lcd_port_pkg::WIDE_W-1:0]       wide_port_pin_i,
  output logic      [lcd_port_pkg::WIDE_W-1:0]       wide_port_pin_o,
  output logic      [lcd_port_pkg::WIDE_W-1:0]       wide_port_pin_oe_o,
  input  wire logic [lcd_port_pkg::NARROW_W-1:0]     narrow_port_pin_i,
  output logic      [lcd_port_pkg::NARROW_W-1:0]     narrow_port_pin_o,
  output logic      [lcd_port_pkg::NARROW_W-1:0]     narrow_port_pin_oe_o
);
  import lcd_port_pkg::*;

  typedef struct packed {
    bus_phase_t       phase;
    logic             write;
    logic [IDX_W-1:0] idx;
    logic [31:0]      hrdata;
    logic             hreadyout;
  } bus_state_t;

  bus_state_t bus_reg;
  bus_state_t bus_next;

  logic                wide_float;
  logic                wide_hold;
  logic                narrow_float;
  logic                narrow_hold;
  logic [WIDE_W-1:0]   wide_rd;
  logic [NARROW_W-1:0] narrow_rd;
  logic                addr_take;
  logic                in_range;
  logic                data_cycle;
  logic                wr_wide_data;
  logic                wr_wide_dir;
  logic                wr_narrow_data;
  logic                wr_narrow_dir;
  logic [REG_W-1:0]    rd_byte;

  lcd_pin_mode_decode #(
    .HOLD_IN_SUBSLEEP (1'b1)
  ) u_wide_mode (
    .power_mode_i (power_mode_i),
    .float_o      (wide_float),
    .hold_o       (wide_hold)
  );

  lcd_pin_mode_decode #(
    .HOLD_IN_SUBSLEEP (1'b1)
  ) u_narrow_mode (
    .power_mode_i (power_mode_i),
    .float_o      (narrow_float),
    .hold_o       (narrow_hold)
  );

  // upper address bits must be zero, else the access is unmapped
  assign in_range   = (haddr_i[31:IDX_MSB+1] == '0);
  assign addr_take  = hsel_i && hready_i && htrans_i[1] && in_range;
  assign data_cycle = (bus_reg.phase == BUS_DATA);

  assign wr_wide_data   = data_cycle && bus_reg.write && (bus_reg.idx == WIDE_DATA_IDX);
  assign wr_wide_dir    = data_cycle && bus_reg.write && (bus_reg.idx == WIDE_DIR_IDX);
  assign wr_narrow_data = data_cycle && bus_reg.write && (bus_reg.idx == NARROW_DATA_IDX);
  assign wr_narrow_dir  = data_cycle && bus_reg.write && (bus_reg.idx == NARROW_DIR_IDX);

  lcd_port_slice #(
    .WIDTH (WIDE_W)
  ) u_wide (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .wr_data_i (wr_wide_data),
    .wr_dir_i  (wr_wide_dir),
    .wdata_i   (hwdata_i[WIDE_W-1:0]),
    .pin_i     (wide_port_pin_i),
    .float_i   (wide_float),
    .hold_i    (wide_hold),
    .rd_data_o (wide_rd),
    .pin_o     (wide_port_pin_o),
    .pin_oe_o  (wide_port_pin_oe_o)
  );

  lcd_port_slice #(
    .WIDTH (NARROW_W)
  ) u_narrow (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .wr_data_i (wr_narrow_data),
    .wr_dir_i  (wr_narrow_dir),
    .wdata_i   (hwdata_i[NARROW_W-1:0]),
    .pin_i     (narrow_port_pin_i),
    .float_i   (narrow_float),
    .hold_i    (narrow_hold),
    .rd_data_o (narrow_rd),
    .pin_o     (narrow_port_pin_o),
    .pin_oe_o  (narrow_port_pin_oe_o)
  );

  always_comb begin
    rd_byte = '0;
    unique case (bus_reg.idx)
      WIDE_DATA_IDX: begin
        rd_byte = wide_rd;
      end
      NARROW_DATA_IDX: begin
        rd_byte = {NARROW_UPPER_ONES, narrow_rd};
      end
      WIDE_DIR_IDX, NARROW_DIR_IDX: begin
        rd_byte = DIR_READ_VALUE;
      end
      default: begin
        rd_byte = '0;
      end
    endcase
  end

  // one wait state per transfer so read data leaves a flip-flop
  always_comb begin
    bus_next = bus_reg;
    if (data_cycle) begin
      bus_next.hreadyout = 1'b1;
      bus_next.hrdata    = bus_reg.write ? '0 : {{(32-REG_W){1'b0}}, rd_byte};
      bus_next.phase     = BUS_IDLE;
    end else if (addr_take) begin
      bus_next.phase     = BUS_DATA;
      bus_next.write     = hwrite_i;
      bus_next.idx       = haddr_i[IDX_MSB:IDX_LSB];
      bus_next.hreadyout = 1'b0;
    end else begin
      bus_next.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reg           <= '0;
      bus_reg.phase     <= BUS_IDLE;
      bus_reg.hreadyout <= 1'b1;
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign hrdata_o    = bus_reg.hrdata;
  assign hreadyout_o = bus_reg.hreadyout;
  assign hresp_o     = HRESP_OKAY;

endmodule
`default_nettype wire

// *** lcd_ports_checker.sv ***
`default_nettype none
module lcd_ports_checker
  import lcd_port_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire power_mode_t power_mode_i,
  input wire logic [7:0]  wide_port_pin_o,
  input wire logic [7:0]  wide_port_pin_oe_o,
  input wire logic [3:0]  narrow_port_pin_o,
  input wire logic [3:0]  narrow_port_pin_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic [15:0] idx;
  logic        take;
  logic        run;
  logic        hold;
  assign idx  = haddr_i[IDX_MSB:IDX_LSB];
  assign take = hsel_i && hready_i && htrans_i[1] && haddr_i[31:18] == 14'h0;
  assign run  = power_mode_i inside {MODE_ACTIVE, MODE_SUBACTIVE};
  assign hold = power_mode_i inside {MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH};
  sequence s_wait;
    ##1 !hreadyout_o ##1 hreadyout_o;
  endsequence
  sequence s_rd;
    take && !hwrite_i;
  endsequence
  sequence s_wr(logic [15:0] i);
    take && hwrite_i && idx == i && run;
  endsequence
  property p_wait;
    take |-> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_dir_rd;
    s_rd ##0 (idx == WIDE_DIR_IDX || idx == NARROW_DIR_IDX) |-> ##2 hrdata_o == 32'h000000FF;
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read");
  property p_narrow_up;
    s_rd ##0 idx == NARROW_DATA_IDX |-> ##2 hrdata_o[7:4] == 4'hF;
  endproperty
  a_narrow_up: assert property (p_narrow_up) else $error("upper bits");
  property p_wide_oe;
    s_wr(WIDE_DIR_IDX) |-> ##3 wide_port_pin_oe_o == $past(hwdata_i[7:0], 2);
  endproperty
  a_wide_oe: assert property (p_wide_oe) else $error("wide enable");
  property p_narrow_oe;
    s_wr(NARROW_DIR_IDX) |-> ##3 narrow_port_pin_oe_o == $past(hwdata_i[3:0], 2);
  endproperty
  a_narrow_oe: assert property (p_narrow_oe) else $error("narrow enable");
  property p_wide_out;
    s_wr(WIDE_DATA_IDX) |-> ##3 wide_port_pin_o == $past(hwdata_i[7:0], 2);
  endproperty
  a_wide_out: assert property (p_wide_out) else $error("wide output");
  property p_float;
    (power_mode_i == MODE_STANDBY) [*2] |-> wide_port_pin_oe_o == 8'h00 && narrow_port_pin_oe_o == 4'h0;
  endproperty
  a_float: assert property (p_float) else $error("standby drive");
  property p_hold;
    hold [*2] |=> $stable(wide_port_pin_oe_o) && $stable(wide_port_pin_o)
      && $stable(narrow_port_pin_oe_o) && $stable(narrow_port_pin_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pins not held");
endmodule
bind lcd_internal_io_ports lcd_ports_checker lcd_ports_checker_inst (.mclk_i, .arst_n_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o,
  .power_mode_i, .wide_port_pin_o, .wide_port_pin_oe_o, .narrow_port_pin_o,
  .narrow_port_pin_oe_o);
`default_nettype wire

// *** lcd_ctrl_model.sv ***
`default_nettype none
module lcd_ctrl_model (
  input  wire logic [7:0] wide_drive_i,
  input  wire logic [7:0] wide_out_i,
  input  wire logic [7:0] wide_oe_i,
  input  wire logic [3:0] narrow_drive_i,
  input  wire logic [3:0] narrow_out_i,
  input  wire logic [3:0] narrow_oe_i,
  output logic      [7:0] wide_level_o,
  output logic      [3:0] narrow_level_o
);
  assign wide_level_o   = (wide_oe_i & wide_out_i) | (~wide_oe_i & wide_drive_i);
  assign narrow_level_o = (narrow_oe_i & narrow_out_i) | (~narrow_oe_i & narrow_drive_i);
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import lcd_port_pkg::*;
  logic        mclk = 0, arst_n = 0, hsel = 0, hwrite = 0, rd_pend = 0, hready, hresp;
  logic [1:0]  htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  power_mode_t mode = MODE_ACTIVE;
  logic [7:0]  wdrv = '0, d, m, nd, nm, a, e, wpin, wo, woe, lw;
  logic [3:0]  ndrv = '0, b, npin, no, noe, ln;
  logic [7:0]  exp_q[$];
  int          bad_count = 0, num_checks = 0, cyc = 0;
  lcd_internal_io_ports lcd_internal_io_ports_inst (
    .mclk_i(mclk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .power_mode_i(mode),
    .wide_port_pin_i(wpin), .wide_port_pin_o(wo), .wide_port_pin_oe_o(woe),
    .narrow_port_pin_i(npin), .narrow_port_pin_o(no), .narrow_port_pin_oe_o(noe));
  lcd_ctrl_model lcd_ctrl_model_inst (
    .wide_drive_i(wdrv), .wide_out_i(wo), .wide_oe_i(woe), .narrow_drive_i(ndrv),
    .narrow_out_i(no), .narrow_oe_i(noe), .wide_level_o(wpin), .narrow_level_o(npin));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reads leave their expected byte here for the monitor
  task xfer(input logic w, input logic [15:0] idx, input logic [7:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    if (!w) begin
      exp_q.push_back(v);
      rd_pend <= 1'b1;
    end
    do @(posedge mclk); while (hready !== 1'b1);
    rd_pend <= 1'b0;
  endtask
  task pins(input logic [7:0] o, input logic [7:0] oe, input logic [3:0] n, input logic [3:0] ne);
    repeat (3) @(posedge mclk);
    chk({8'h0, wo, woe, no, noe}, {8'h0, o, oe, n, ne});
  endtask
  task init_regs;
    a = 8'($urandom);
    b = 4'($urandom);
    wdrv <= a;
    ndrv <= b;
    pins(8'h00, 8'h00, 4'h0, 4'h0); // reset pins
    xfer(1'b0, WIDE_DATA_IDX, a); // pin level read
    xfer(1'b0, NARROW_DATA_IDX, {4'hF, b}); // reset read
    xfer(1'b0, WIDE_DIR_IDX, 8'hFF); // reads ones
    xfer(1'b0, NARROW_DIR_IDX, 8'hFF); // reads ones
    xfer(1'b0, 16'h0000, 8'h00); // unmapped read
    $display("reset test done");
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 4000) begin
      bad_count++;
      finish_test();
    end else if (rd_pend && hready === 1'b1) begin
      chk(hrdata, {24'h0, exp_q.pop_front()}); // read
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY}); // bus response
    end
  end
  initial begin
    void'($urandom(67));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    init_regs();
    repeat (4) begin
      {d, m, nd, nm} = $urandom;
      xfer(1'b1, WIDE_DATA_IDX, d);
      xfer(1'b1, WIDE_DIR_IDX, m);
      xfer(1'b1, NARROW_DATA_IDX, nd);
      xfer(1'b1, NARROW_DIR_IDX, nm);
      xfer(1'b0, WIDE_DATA_IDX, (d & m) | (a & ~m)); // mixed read
      xfer(1'b0, NARROW_DATA_IDX, {4'hF, (nd[3:0] & nm[3:0]) | (b & ~nm[3:0])});
      xfer(1'b0, WIDE_DIR_IDX, 8'hFF); // ones after write
      pins(d, m, nd[3:0], nm[3:0]); // pin drive
    end
    $display("data test done");
    for (int i = 1; i < 6; i++) begin
      m = 8'($urandom);
      mode <= MODE_ACTIVE;
      xfer(1'b1, WIDE_DIR_IDX, m);
      xfer(1'b1, NARROW_DIR_IDX, m);
      repeat (2) @(posedge mclk);
      mode <= power_mode_t'(i);
      xfer(1'b1, WIDE_DIR_IDX, ~m);
      xfer(1'b1, NARROW_DIR_IDX, ~m);
      e = (i == 1) ? ~m : (i == 5) ? 8'h00 : m;
      pins(d, e, nd[3:0], e[3:0]); // mode states
      // held pins differ from the new direction, so data and pin reads part ways
      lw = (~m & d) | (m & ((e & d) | (~e & a)));
      ln = (~m[3:0] & nd[3:0]) | (m[3:0] & ((e[3:0] & nd[3:0]) | (~e[3:0] & b)));
      xfer(1'b0, WIDE_DATA_IDX, lw); // direction vs held pin
      xfer(1'b0, NARROW_DATA_IDX, {4'hF, ln}); // direction vs held pin
    end
    mode <= MODE_ACTIVE;
    $display("mode test done");
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    init_regs();
    finish_test();
  end
endmodule
`default_nettype wire
